// [design/apms_pkg.sv]
// constants, register map and enumerations of the amplifier power sequencer
// assumes one 10 MHz clock and a byte-addressed plain register port
// What this block does
// - In hardware mode all strap outputs (bridge, switching frequency, gain) are set first.
// - Shutdown stays low, and in hardware mode sleep stays high, while supplies ramp.
// - The audio clocks start only after the supplies are reported stable.
// - In hardware mode shutdown is released only with supplies, clocks and straps settled.
// - In hardware mode sleep goes low only after shutdown has been released.
// - Hardware shutdown drives sleep high, then shutdown low, then stops clocks and supplies.
// - Software mode straps the two gain select outputs to binary 11 before power-up.
// - In software mode, after clocks start, a configuration write that mutes is issued.
// - In software mode shutdown is released only after the configuration write completes.
// - In software mode an unmute write follows the release of shutdown.
// - Software shutdown mutes over the control port, then drives shutdown low, then powers off.
// - Control writes other than volume are issued only while shutdown is held low.
// - Latching faults are cleared by toggling the shutdown pin.
package apms_pkg;

    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned WAIT_W      = 16;

    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_CFG    = 4'h4;
    localparam logic [3:0]  ADDR_WAIT   = 4'h8;
    localparam logic [3:0]  ADDR_STAT   = 4'hc;

    localparam int unsigned CTRL_START   = 0;
    localparam int unsigned CTRL_STOP    = 1;
    localparam int unsigned CTRL_RECOVER = 2;

    localparam int unsigned CFG_SW      = 0;
    localparam int unsigned CFG_BRIDGE  = 1;
    localparam int unsigned CFG_SWITCH_SELECT_A_LO = 2;
    localparam int unsigned CFG_GAIN_LO = 4;
    localparam int unsigned CFG_ADDR    = 6;
    localparam int unsigned CFG_W       = 7;

    localparam logic [6:0]  CFG_RST     = 7'h00;
    localparam logic [15:0] WAIT_RST    = 16'h0010;
    localparam logic [1:0]  GAIN_SW     = 2'h3;

    typedef enum logic [1:0] {
        CP_NONE,
        CP_CONFIG_MUTE,
        CP_UNMUTE,
        CP_MUTE
    } apms_cp_e;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_STRAP,
        ST_SUPPLY,
        ST_CLOCK,
        ST_CONFIG,
        ST_RELEASE,
        ST_WAKE,
        ST_UNMUTE,
        ST_RUN,
        ST_QUIET,
        ST_SDOWN,
        ST_CLKOFF
    } apms_state_e;

endpackage

// [design/apms_ctrl.sv]
// power-mode sequencer that drives the amplifier's pins and control-port requests
// assumes an external control-port engine that answers each request with cp_done_in
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
module apms_ctrl (
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic [apms_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [apms_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [apms_pkg::DATA_W-1:0] rdata_out,
    input  wire logic                        supply_stable_in,
    input  wire logic                        clock_stable_in,
    input  wire logic                        cp_done_in,
    input  wire logic                        overcurrent_fault_in,
    input  wire logic                        output_dc_fault_in,
    input  wire logic                        overtemp_fault_in,
    output logic                             supply_en_out,
    output logic                             clock_en_out,
    output logic                             speaker_shutdown_n_out,
    output logic                             speaker_sleep_addr_sel_out,
    output logic      [1:0]                  gain_select_out,
    output logic                             parallel_bridge_select_out,
    output logic      [1:0]                  switch_select_a_out,
    output logic                             cp_req_out,
    output apms_pkg::apms_cp_e               cp_cmd_out
);
    import apms_pkg::*;

    apms_state_e            state_q;
    apms_state_e            state_d;
    logic [WAIT_W-1:0]      gap_q;
    logic [WAIT_W-1:0]      wait_q;
    logic [CFG_W-1:0]       cfg_q;
    logic                   sw_mode_q;
    logic                   start_q;
    logic                   stop_q;
    logic                   recover_q;
    logic                   in_recover_q;

    wire                    gap_zero   = (gap_q == '0);
    wire                    moving     = (state_d != state_q);
    wire                    wr_ctrl    = wr_in && (addr_in == ADDR_CTRL);
    wire                    wr_cfg     = wr_in && (addr_in == ADDR_CFG);
    wire                    wr_wait    = wr_in && (addr_in == ADDR_WAIT);
    wire                    take_start = (state_q == ST_IDLE) && moving;
    wire                    take_stop  = (state_q == ST_RUN) && moving;
    wire                    enter_str  = moving && (state_d == ST_STRAP);
    wire                    clocks_ok  = supply_stable_in && clock_stable_in;

    function automatic logic sd_high(input apms_state_e s);
        return (s == ST_RELEASE) || (s == ST_WAKE) || (s == ST_UNMUTE) ||
               (s == ST_RUN) || (s == ST_QUIET);
    endfunction

    function automatic logic clk_on(input apms_state_e s);
        return !((s == ST_IDLE) || (s == ST_STRAP) || (s == ST_SUPPLY) ||
                 (s == ST_CLKOFF));
    endfunction

    function automatic apms_cp_e cp_of(input apms_state_e s, input logic sw);
        if (s == ST_CONFIG) begin
            return CP_CONFIG_MUTE;
        end else if (s == ST_UNMUTE) begin
            return CP_UNMUTE;
        end else if ((s == ST_QUIET) && sw) begin
            return CP_MUTE;
        end else begin
            return CP_NONE;
        end
    endfunction

    // sleep is low only in the settled hardware-mode states; in software
    // mode the same pin is the address strap from the config register
    wire sleep_hw = !((state_d == ST_WAKE) || (state_d == ST_RUN));
    wire sleep_d  = sw_mode_q ? cfg_q[CFG_ADDR] : sleep_hw;
    wire [1:0] gain_d = cfg_q[CFG_SW] ? GAIN_SW
                                      : cfg_q[CFG_GAIN_LO +: 2];
    wire apms_cp_e cmd_d = cp_of(state_d, sw_mode_q);

    // steps out of supply and clock wait for both their indication and the programmed gap; the other timed steps for the gap only
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:    if (start_q) begin
                state_d = ST_STRAP;
            end
            ST_STRAP:   if (gap_zero) begin
                state_d = ST_SUPPLY;
            end
            ST_SUPPLY:  if (gap_zero && supply_stable_in) begin
                state_d = ST_CLOCK;
            end
            ST_CLOCK:   if (gap_zero && clocks_ok) begin
                state_d = sw_mode_q ? ST_CONFIG : ST_RELEASE;
            end
            ST_CONFIG:  if (cp_done_in) begin
                state_d = ST_RELEASE;
            end
            ST_RELEASE: if (gap_zero) begin
                state_d = sw_mode_q ? ST_UNMUTE : ST_WAKE;
            end
            ST_WAKE:    if (gap_zero) begin
                state_d = ST_RUN;
            end
            ST_UNMUTE:  if (cp_done_in) begin
                state_d = ST_RUN;
            end
            ST_RUN:     if (stop_q || recover_q) begin
                state_d = ST_QUIET;
            end
            ST_QUIET:   if (sw_mode_q ? cp_done_in : gap_zero) begin
                state_d = ST_SDOWN;
            end
            ST_SDOWN:   if (gap_zero) begin
                state_d = in_recover_q ? ST_RELEASE : ST_CLKOFF;
            end
            ST_CLKOFF:  if (gap_zero) begin
                state_d = ST_IDLE;
            end
            default:    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            gap_q   <= '0;
        end else begin
            state_q <= state_d;
            gap_q   <= moving ? wait_q : (gap_zero ? gap_q : gap_q - 1'b1);
        end
    end

    // a command arriving in the cycle it is taken is kept (set wins)
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_q   <= 1'b0;
            stop_q    <= 1'b0;
            recover_q <= 1'b0;
        end else begin
            start_q   <= (start_q && !take_start) || (wr_ctrl && wdata_in[CTRL_START]);
            stop_q    <= (stop_q && !take_stop) || (wr_ctrl && wdata_in[CTRL_STOP]);
            recover_q <= (recover_q && !take_stop) || (wr_ctrl && wdata_in[CTRL_RECOVER]);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            in_recover_q <= 1'b0;
        end else if (take_stop) begin
            in_recover_q <= recover_q && !stop_q;
        end else if (state_q == ST_RUN) begin
            in_recover_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q  <= CFG_RST;
            wait_q <= WAIT_RST;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wdata_in[CFG_W-1:0];
            end
            if (wr_wait) begin
                wait_q <= wdata_in[WAIT_W-1:0];
            end
        end
    end

    // straps and mode are frozen at the start of a power-up
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sw_mode_q                  <= 1'b0;
            gain_select_out            <= 2'h0;
            parallel_bridge_select_out <= 1'b0;
            switch_select_a_out        <= 2'h0;
        end else if (enter_str) begin
            sw_mode_q                  <= cfg_q[CFG_SW];
            gain_select_out            <= gain_d;
            parallel_bridge_select_out <= cfg_q[CFG_BRIDGE];
            switch_select_a_out        <= cfg_q[CFG_SWITCH_SELECT_A_LO +: 2];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            supply_en_out              <= 1'b0;
            clock_en_out               <= 1'b0;
            speaker_shutdown_n_out     <= 1'b0;
            speaker_sleep_addr_sel_out <= 1'b1;
            cp_req_out                 <= 1'b0;
            cp_cmd_out                 <= CP_NONE;
        end else begin
            supply_en_out              <= (state_d != ST_IDLE) && (state_d != ST_STRAP);
            clock_en_out               <= clk_on(state_d);
            speaker_shutdown_n_out     <= sd_high(state_d);
            speaker_sleep_addr_sel_out <= sleep_d;
            cp_req_out                 <= moving && (cmd_d != CP_NONE);
            cp_cmd_out                 <= cmd_d;
        end
    end

    wire [DATA_W-1:0] stat_word = {{(DATA_W-12){1'b0}}, overtemp_fault_in,
                                   output_dc_fault_in, overcurrent_fault_in,
                                   clock_stable_in, supply_stable_in, sw_mode_q,
                                   in_recover_q, start_q, state_q};
    wire [DATA_W-1:0] rd_mux =
        (addr_in == ADDR_CTRL) ? {{(DATA_W-3){1'b0}}, recover_q, stop_q, start_q} :
        (addr_in == ADDR_CFG)  ? {{(DATA_W-CFG_W){1'b0}}, cfg_q} :
        (addr_in == ADDR_WAIT) ? {{(DATA_W-WAIT_W){1'b0}}, wait_q} :
        (addr_in == ADDR_STAT) ? stat_word : '0;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= rd_in ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_ramp_in_shutdown: assert property ($rose(supply_en_out) |->
        !speaker_shutdown_n_out && (sw_mode_q || speaker_sleep_addr_sel_out))
        else $error("supplies ramped outside shutdown");
    // the pins are registered from state_d, so the state that launched an
    // edge is the one sampled one clock before the edge is seen
    a_straps_first: assert property ($rose(supply_en_out) |->
        $past(state_q) == ST_STRAP)
        else $error("supplies enabled before straps were set");
    a_clock_after_supply: assert property ($rose(clock_en_out) |->
        $past(supply_stable_in) && supply_en_out)
        else $error("clocks started before supplies were stable");
    a_release_when_ready: assert property ($rose(speaker_shutdown_n_out) |->
        $past(clocks_ok || in_recover_q) && clock_en_out)
        else $error("shutdown released before supplies and clocks were stable");
    a_sleep_after_release: assert property (
        !sw_mode_q && $fell(speaker_sleep_addr_sel_out) |-> speaker_shutdown_n_out)
        else $error("sleep dropped while still in shutdown");
    a_hw_down_order: assert property (
        !sw_mode_q && $fell(speaker_shutdown_n_out) |->
        speaker_sleep_addr_sel_out && $past(speaker_sleep_addr_sel_out))
        else $error("shutdown dropped before sleep was raised");
    a_sw_gain_strap: assert property (sw_mode_q && supply_en_out |->
        gain_select_out == GAIN_SW)
        else $error("software mode without gain strap 11");
    a_cfg_in_shutdown: assert property (
        cp_req_out && (cp_cmd_out == CP_CONFIG_MUTE) |-> !speaker_shutdown_n_out
        ##1 !speaker_shutdown_n_out)
        else $error("configuration write outside shutdown");
    a_release_after_cfg: assert property (
        sw_mode_q && $rose(speaker_shutdown_n_out) && !in_recover_q |->
        $past(state_q) == ST_CONFIG)
        else $error("software release before configuration finished");
    a_unmute_released: assert property (
        cp_req_out && (cp_cmd_out == CP_UNMUTE) |-> speaker_shutdown_n_out)
        else $error("unmute issued while in shutdown");
    a_sw_mute_first: assert property (
        sw_mode_q && $fell(speaker_shutdown_n_out) |-> $past(state_q) == ST_QUIET)
        else $error("software shutdown without a prior mute");
    a_pin_gap: assert property (
        $changed(speaker_shutdown_n_out) || $changed(clock_en_out) |->
        $past(gap_zero) || $past(state_q) == ST_IDLE ||
        $past(state_q) == ST_CONFIG || $past(state_q) == ST_UNMUTE ||
        $past(state_q) == ST_RUN || $past(state_q) == ST_QUIET)
        else $error("pin changed before the programmed gap elapsed");

    // straps must not move under a powered device; they are only
    // re-latched on the way into a new power-up, with supplies off
    a_straps_frozen: assert property (supply_en_out |->
        $stable(gain_select_out) && $stable(parallel_bridge_select_out) &&
        $stable(switch_select_a_out))
        else $error("strap output changed while supplies were on");

    // clocks may only stop once the device sits in shutdown,
    // and in hardware mode with sleep already raised
    a_clock_stop_safe: assert property ($fell(clock_en_out) |->
        !speaker_shutdown_n_out && (sw_mode_q || speaker_sleep_addr_sel_out))
        else $error("clocks stopped outside shutdown");

    // supplies are the very last thing to go
    a_supply_off_last: assert property ($fell(supply_en_out) |->
        !speaker_shutdown_n_out && !clock_en_out)
        else $error("supplies removed with clocks or shutdown still up");

    // the control-port engine takes one request per pulse; a stretched
    // pulse would be seen as a second write
    a_cp_req_pulse: assert property (cp_req_out |=> !cp_req_out)
        else $error("control-port request longer than one cycle");

    // hardware mode has no control port at all
    a_hw_no_cp: assert property (!sw_mode_q |-> !cp_req_out)
        else $error("control-port request in hardware mode");

    // the configuration write carries the mute, so it must come while
    // the clocks run and before shutdown is released
    a_cfg_clocks_on: assert property (
        cp_req_out && (cp_cmd_out == CP_CONFIG_MUTE) |-> clock_en_out && supply_en_out)
        else $error("configuration write without clocks running");

    // the mute of a software shutdown is sent while still released
    a_mute_released: assert property (
        cp_req_out && (cp_cmd_out == CP_MUTE) |-> speaker_shutdown_n_out)
        else $error("mute issued after shutdown was already low");

    // fault recovery is a real toggle: shutdown goes low and comes back
    // without the supplies being dropped on the way
    a_recover_toggle: assert property (
        in_recover_q && $rose(speaker_shutdown_n_out) |-> supply_en_out && clock_en_out)
        else $error("recovery release without supplies and clocks");

    c_hw_run: cover property (!sw_mode_q && state_q == ST_RUN);
    c_sw_run: cover property (sw_mode_q && state_q == ST_RUN);
    c_recover: cover property (in_recover_q && state_q == ST_RELEASE);
    c_power_off: cover property (state_q == ST_CLKOFF ##1 state_q == ST_IDLE);
    c_sw_mute: cover property (cp_req_out && cp_cmd_out == CP_MUTE);

endmodule

// [tb/apms_dev_model.sv]
// behavioural amplifier device seen from the sequencer's pins and control-port engine
// assumes the sequencer's clock; supplies and clocks report stable three cycles after enable
`timescale 1ns/100ps
module apms_dev_model (
    input  wire logic               sys_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               supply_en_in,
    input  wire logic               clock_en_in,
    input  wire logic               speaker_shutdown_n_in,
    input  wire logic [1:0]         gain_select_in,
    input  wire logic               cp_req_in,
    input  wire apms_pkg::apms_cp_e cp_cmd_in,
    input  wire logic [2:0]         fault_in,
    output logic                    supply_stable_out,
    output logic                    clock_stable_out,
    output logic                    cp_done_out,
    output logic      [2:0]         fault_out,
    output logic                    muted_out,
    output logic                    viol_out
);
    import apms_pkg::*;
    logic [2:0] sup_q;
    logic [2:0] clk_q;
    logic       pend_q;
    logic       cfg_q;
    logic       sd_q;
    wire        sw_mode = (gain_select_in == GAIN_SW);
    assign supply_stable_out = sup_q[2];
    assign clock_stable_out  = clk_q[2];
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sup_q <= 3'h0; clk_q <= 3'h0; pend_q <= 1'b0; cfg_q <= 1'b0; sd_q <= 1'b0;
            cp_done_out <= 1'b0; fault_out <= 3'h0; muted_out <= 1'b1; viol_out <= 1'b0;
        end else begin
            sup_q  <= supply_en_in ? {sup_q[1:0], 1'b1} : 3'h0;
            // clock error is not latched: valid again three cycles after clocks run
            clk_q  <= clock_en_in ? {clk_q[1:0], 1'b1} : 3'h0;
            pend_q <= cp_req_in;
            cp_done_out <= pend_q;
            sd_q   <= speaker_shutdown_n_in;
            if (!supply_en_in) cfg_q <= 1'b0;
            if (cp_req_in) begin
                // configuration only while held in shutdown, never in hardware mode
                if (!sw_mode || (cp_cmd_in == CP_CONFIG_MUTE && speaker_shutdown_n_in)) viol_out <= 1'b1;
                if (cp_cmd_in == CP_CONFIG_MUTE) cfg_q <= 1'b1;
                muted_out <= (cp_cmd_in != CP_UNMUTE);
            end
            if (sw_mode && speaker_shutdown_n_in && !sd_q && !cfg_q) viol_out <= 1'b1;
            if (sw_mode && !speaker_shutdown_n_in && sd_q && !muted_out) viol_out <= 1'b1;
            // latching faults clear only while the shutdown pin is low
            if (!speaker_shutdown_n_in) fault_out <= 3'h0;
            else fault_out <= fault_out | fault_in;
        end
    end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the amplifier power sequencer with a device model
// assumes the register map and state codes of the sequencer package
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import apms_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        sup_st, clk_st, cp_done, sup_en, clk_en, sd_n, sleep, bridge, cp_req;
    logic        muted, viol;
    logic [1:0]  gain, switch_select_a;
    logic [2:0]  fault_inj = 3'h0;
    logic [2:0]  fault;
    apms_cp_e    cp_cmd;
    logic        sw_mode = 1'b0;
    int          bad_count = 0;
    int          compares = 0;
    always #50 clk = ~clk;
    apms_ctrl dut (.sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .supply_stable_in(sup_st),
        .clock_stable_in(clk_st), .cp_done_in(cp_done), .overcurrent_fault_in(fault[0]),
        .output_dc_fault_in(fault[1]), .overtemp_fault_in(fault[2]), .supply_en_out(sup_en),
        .clock_en_out(clk_en), .speaker_shutdown_n_out(sd_n),
        .speaker_sleep_addr_sel_out(sleep), .gain_select_out(gain),
        .parallel_bridge_select_out(bridge), .switch_select_a_out(switch_select_a), .cp_req_out(cp_req),
        .cp_cmd_out(cp_cmd));
    apms_dev_model u_dev (.sys_clk_in(clk), .rst_n_in(rst_n), .supply_en_in(sup_en),
        .clock_en_in(clk_en), .speaker_shutdown_n_in(sd_n), .gain_select_in(gain),
        .cp_req_in(cp_req), .cp_cmd_in(cp_cmd), .fault_in(fault_inj),
        .supply_stable_out(sup_st), .clock_stable_out(clk_st), .cp_done_out(cp_done),
        .fault_out(fault), .muted_out(muted), .viol_out(viol));
    // pin ordering watched on every cycle, away from the sampling edge
    always @(negedge clk) begin
        if (rst_n) begin
            `CHK("clock_before_supply", 1'b0, clk_en & ~sup_st)
            `CHK("release_unstable", 1'b0, sd_n & ~(sup_st & clk_st))
            `CHK("sleep_low_in_shutdown", 1'b0, ~sw_mode & ~sleep & ~sd_n)
        end
    end
    task automatic end_sim();
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_state(input logic [3:0] s);
        logic [31:0] d;
        int n;
        d = '1;
        for (n = 0; n < 300 && d[3:0] !== s; n++) bus_rd(ADDR_STAT, d);
        `CHK("state", s, d[3:0])
    endtask
    task automatic t_reset();
        logic [31:0] d;
        `CHK("sd_reset", 1'b0, sd_n)
        `CHK("sleep_reset", 1'b1, sleep)
        `CHK("supply_reset", 1'b0, sup_en)
        `CHK("clock_reset", 1'b0, clk_en)
        bus_rd(ADDR_CFG, d);
        `CHK("cfg_reset", 32'h0, d)
        bus_rd(ADDR_WAIT, d);
        `CHK("wait_reset", 32'h10, d)
        bus_rd(4'h2, d);
        `CHK("unmapped", 32'h0, d)
        bus_rd(ADDR_STAT, d);
        `CHK("stat_reset", 32'h0, d)
    endtask
    task automatic t_run(input logic [6:0] cfg, input logic sw);
        sw_mode = sw;
        bus_wr(ADDR_CFG, {25'h0, cfg});
        bus_wr(ADDR_WAIT, 32'h2);
        bus_wr(ADDR_CTRL, 32'h1);
        wait_state(ST_RUN);
        `CHK("gain", sw ? GAIN_SW : cfg[5:4], gain)
        `CHK("bridge", cfg[1], bridge)
        `CHK("switch_select_a", cfg[3:2], switch_select_a)
        `CHK("sd_run", 1'b1, sd_n)
        `CHK("sleep_run", sw ? cfg[6] : 1'b0, sleep)
        `CHK("power_run", 2'h3, {sup_en, clk_en})
        `CHK("muted_run", 1'b0, sw ? muted : 1'b0)
        `CHK("order_run", 1'b0, viol)
    endtask
    task automatic t_stop(input logic [31:0] cmd);
        bus_wr(ADDR_CTRL, cmd);
        wait_state(ST_IDLE);
        `CHK("sd_off", 1'b0, sd_n)
        `CHK("power_off", 2'h0, {sup_en, clk_en})
        `CHK("muted_off", 1'b1, muted)
        `CHK("order_off", 1'b0, viol)
    endtask
    task automatic t_recover();
        logic [31:0] d;
        // a longer gap keeps the short shutdown step visible to status polling
        bus_wr(ADDR_WAIT, 32'h10);
        @(posedge clk);
        fault_inj <= 3'h5;
        @(posedge clk);
        fault_inj <= 3'h0;
        bus_rd(ADDR_STAT, d);
        `CHK("fault_seen", 3'h5, d[11:9])
        bus_wr(ADDR_CTRL, 32'h4);
        wait_state(ST_SDOWN);
        wait_state(ST_RUN);
        bus_rd(ADDR_STAT, d);
        `CHK("fault_cleared", 3'h0, d[11:9])
        `CHK("sd_resumed", 1'b1, sd_n)
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_run(7'h1a, 1'b0);
        t_recover();
        t_stop(32'h6);
        t_run(7'h45, 1'b1);
        t_stop(32'h2);
        end_sim();
    end
    // a hung sequence cannot reach the closing task otherwise
    initial begin
        #(100 * 50000);
        bad_count++;
        end_sim();
    end
endmodule
